// File: pkg/jsqr_regs.svh
// constants of the status query responder: message ids, bit positions, timing
// assumes inclusion by its bare name from the hw files
// Functional notes
// R1 - requester asks through a standard request message
// R2 - self-test reply: priority 6, group 65363, two bytes
// R3 - self-test bit 0 flags internal software fault
// R4 - bit 1 set during init or over-range
// R5 - bit 2 data error mirrors bit 5
// R6 - bit 3 set until initialization completes
// R7 - bit 4 set while rotation/acceleration over limit
// R8 - algorithm reset command clears algorithm faults
// R9 - bit 6 flags checksum fault or nvm write
// R10 - status reply: priority 6, group 65364, two bytes
// R11 - status bit 0 is OR of alerts; code ORs bits 1-3 only, attitude bit 10 stays out
// R12 - bits 1,2,3,10 carry the programmable alerts
// R13 - status bit 7 shows nvm write open
// R14 - status bit 8 shows algorithm starting
// R15 - status bit 11 shows yaw turn indicator
// R16 - status bit 12 shows over-range; controller resets
// R17 - set commands broadcast; foreign address discarded
// R18 - save command: priority 6, group 65361, three bytes
// R19 - unit answers save with success or failure
// R20 - save bytes: kind, address, success flag
// R21 - reserved bits always read zero
`ifndef JSQR_REGS_SVH
`define JSQR_REGS_SVH
// ----------------------------------------------------------------
// message identities
// ----------------------------------------------------------------
`define JSQR_PRIO 3'h6
`define JSQR_PF 8'hff
`define JSQR_PS_ALGO_RESET 8'h50
`define JSQR_PS_SAVE 8'h51
`define JSQR_PS_SELFTEST 8'h53
`define JSQR_PS_STATUS 8'h54
`define JSQR_LEN_WORD 4'h2
`define JSQR_LEN_SAVE 4'h3
// ----------------------------------------------------------------
// save payload byte values
// ----------------------------------------------------------------
`define JSQR_SAVE_REQ 8'h00
`define JSQR_SAVE_RSP 8'h01
`define JSQR_SAVE_FAIL 8'h00
`define JSQR_SAVE_OK 8'h01
// ----------------------------------------------------------------
// self-test word bit positions
// ----------------------------------------------------------------
`define JSQR_ST_SWF 0
`define JSQR_ST_ALGO 1
`define JSQR_ST_DATA 2
`define JSQR_ST_INIT 3
`define JSQR_ST_RANGE 4
`define JSQR_ST_DMIR 5
`define JSQR_ST_CAL 6
// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define JSQR_SS_SUM 0
`define JSQR_SS_HW 1
`define JSQR_SS_SW 2
`define JSQR_SS_SENS 3
`define JSQR_SS_NVM 7
`define JSQR_SS_START 8
`define JSQR_SS_ATT 10
`define JSQR_SS_YAW 11
`define JSQR_SS_LIMIT 12
// ----------------------------------------------------------------
// timing: startup time in ms, cycles at 100 MHz
// ----------------------------------------------------------------
`define JSQR_INIT_MS 2000
`define JSQR_CLK_KHZ 100000
`define JSQR_INIT_CYCLES (`JSQR_INIT_MS * `JSQR_CLK_KHZ)
`endif

// File: pkg/jsqr_pkg.sv
// types of the status query link: the message frame both ends share, the responder states
// assumes the constants header sits beside it
package jsqr_pkg;
  // message frame as carried on the link
  typedef struct packed {
    logic [2:0] prio;
    logic [7:0] pf;
    logic [7:0] ps;
    logic [7:0] src;
    logic [3:0] len;
    logic [23:0] data;
  } jsqr_msg_type;
  // responder sequencing
  typedef enum logic [1:0] {
    JSQR_IDLE,
    JSQR_SAVING,
    JSQR_REPLY
  } jsqr_state_type;
endpackage

// File: pkg/jsqr_link_if.sv
// message link between the controller and the responder
// assumes one shared clock and reset, valid/ready handshakes each way
`timescale 1ns/1ps
interface jsqr_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  // controller to responder
  logic reqValid;
  logic reqReady;
  jsqr_pkg::jsqr_msg_type reqMsg;
  // responder to controller
  logic rspValid;
  logic rspReady;
  jsqr_pkg::jsqr_msg_type rspMsg;
  modport responder (
    input clk, rst_n, reqValid, reqMsg, rspReady,
    output reqReady, rspValid, rspMsg
  );
  modport controller (
    input clk, rst_n, reqReady, rspValid, rspMsg,
    output reqValid, reqMsg, rspReady
  );
endinterface

// File: hw/jsqr_startup_timer.sv
// startup timer: holds busy for a set count after reset or restart
// assumes a single clock; restart is a one-cycle pulse
`timescale 1ns/1ps
module jsqr_startup_timer #(
  parameter int unsigned CYCLES = 200000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  // state
  output logic busy
);
  logic [31:0] count; // cycles left
  logic [31:0] next_count;
  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  // next value of the countdown
  always_comb begin
    if (restart) begin
      next_count = CYCLES[31:0];
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
    end else begin
      next_count = count;
    end
  end
  // register; reset loads the full count so startup lasts as long as after a restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= CYCLES[31:0];
    end else begin
      count <= next_count;
    end
  end
  assign busy = (count != 32'h0);
endmodule

// File: hw/jsqr_responder.sv
// responder end: answers self-test and status requests, runs the save exchange
// assumes the controller holds a request until reqReady; one request at a time
`timescale 1ns/1ps
`include "jsqr_regs.svh"
module jsqr_responder #(
  parameter int unsigned INIT_CYCLES = `JSQR_INIT_CYCLES,
  parameter logic [7:0] OWN_ADDR = 8'h80
) (
  // link
  jsqr_link_if.responder link,
  // sensor conditions
  input wire logic swFaultFlag,
  input wire logic rangeExceeded,
  input wire logic dataFaultFlag,
  input wire logic calChecksumFault,
  input wire logic hwAlert,
  input wire logic swAlert,
  input wire logic sensingAlert,
  input wire logic attitudeAlert,
  input wire logic yawTurnIndicator,
  input wire logic nvmWriteOpen,
  // nvm save port
  input wire logic nvmDone,
  input wire logic nvmOk,
  // user side outputs
  output logic nvmSaveStart,
  output logic algoRestart,
  output logic algoStarting
);
  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  jsqr_pkg::jsqr_state_type state; // sequence state
  jsqr_pkg::jsqr_state_type next_state;
  jsqr_pkg::jsqr_msg_type rsp; // pending answer
  jsqr_pkg::jsqr_msg_type next_rsp;
  logic rspValid, next_rspValid;
  logic reqReady, next_reqReady;
  logic saveStart, next_saveStart;
  logic restartPulse, next_restartPulse;
  logic starting, next_starting;
  logic nvmBusy, next_nvmBusy; // save writing to nvm
  logic [7:0] saveReq; // requester of a running save
  logic [7:0] next_saveReq;
  logic initBusy; // timer running
  logic [15:0] selfWord, statusWord;
  logic accept; // request taken this cycle
  logic forUs; // set command addressed here
  logic isSet; // message is a set command
  // ----------------------------------------------------------------
  // startup timer
  // ----------------------------------------------------------------
  // restarted by algorithm reset; shared by reset and restart paths
  jsqr_startup_timer #(.CYCLES(INIT_CYCLES)) timer (
    .clk(link.clk),
    .rst_n(link.rst_n),
    .restart(restartPulse),
    .busy(initBusy)
  );
  // ----------------------------------------------------------------
  // answer words
  // ----------------------------------------------------------------
  // reserved positions stay zero by starting from zero
  // words follow the inputs live; an answer holds them as they stood at the take
  always_comb begin
    // self-test word
    selfWord = 16'h0; // R21
    selfWord[`JSQR_ST_SWF] = swFaultFlag; // R3
    // range input is cleared by the algorithm restart outside too
    selfWord[`JSQR_ST_ALGO] = starting | rangeExceeded; // R4 R8
    selfWord[`JSQR_ST_DATA] = dataFaultFlag; // R5
    selfWord[`JSQR_ST_DMIR] = dataFaultFlag; // R5
    selfWord[`JSQR_ST_INIT] = starting; // R6
    selfWord[`JSQR_ST_RANGE] = rangeExceeded; // R7
    selfWord[`JSQR_ST_CAL] = calChecksumFault | nvmBusy; // R9
    // status word; the attitude alert stays out of the summary bit
    statusWord = 16'h0; // R21
    statusWord[`JSQR_SS_HW] = hwAlert; // R12
    statusWord[`JSQR_SS_SW] = swAlert; // R12
    statusWord[`JSQR_SS_SENS] = sensingAlert; // R12
    statusWord[`JSQR_SS_ATT] = attitudeAlert; // R12
    statusWord[`JSQR_SS_SUM] = hwAlert | swAlert | sensingAlert; // R11
    statusWord[`JSQR_SS_NVM] = nvmWriteOpen; // R13
    statusWord[`JSQR_SS_START] = starting; // R14
    statusWord[`JSQR_SS_YAW] = yawTurnIndicator; // R15
    statusWord[`JSQR_SS_LIMIT] = rangeExceeded; // R16
  end
  // ----------------------------------------------------------------
  // request decode and sequencing
  // ----------------------------------------------------------------
  // decode looks at the request as it stands; it only counts when taken
  assign accept = link.reqValid & reqReady;
  assign isSet = (link.reqMsg.ps == `JSQR_PS_SAVE) || (link.reqMsg.ps == `JSQR_PS_ALGO_RESET);
  assign forUs = (link.reqMsg.data[15:8] == OWN_ADDR); // R17
  // next state, answer and strobes
  always_comb begin
    // defaults: hold state and answer, strobes low
    next_state = state;
    next_rsp = rsp;
    next_rspValid = rspValid;
    next_reqReady = 1'b0;
    next_saveStart = 1'b0;
    next_restartPulse = 1'b0;
    // the restart pulse covers the cycle before the timer reloads, so the
    // startup flag does not drop for one cycle after an algorithm reset
    next_starting = initBusy | restartPulse; // R6 R14
    next_nvmBusy = nvmBusy;
    next_saveReq = saveReq;
    case (state)
      jsqr_pkg::JSQR_IDLE: begin
        // one-cycle ready so each request is taken once
        next_reqReady = link.reqValid & ~reqReady;
        if (accept && link.reqMsg.pf == `JSQR_PF) begin
          next_rsp = '0;
          next_rsp.prio = `JSQR_PRIO;
          next_rsp.pf = `JSQR_PF;
          next_rsp.src = OWN_ADDR;
          next_rsp.ps = link.reqMsg.ps;
          next_reqReady = 1'b0;
          // a set command for another unit is dropped without an answer
          if (isSet && !forUs) begin
            next_state = jsqr_pkg::JSQR_IDLE; // R17
          end else if (link.reqMsg.ps == `JSQR_PS_SELFTEST) begin
            // queries answer at once with the word sampled now
            next_rsp.len = `JSQR_LEN_WORD; // R2
            next_rsp.data = {8'h0, selfWord}; // R2
            next_rspValid = 1'b1;
            next_state = jsqr_pkg::JSQR_REPLY;
          end else if (link.reqMsg.ps == `JSQR_PS_STATUS) begin
            next_rsp.len = `JSQR_LEN_WORD; // R10
            next_rsp.data = {8'h0, statusWord}; // R10
            next_rspValid = 1'b1;
            next_state = jsqr_pkg::JSQR_REPLY;
          end else if (link.reqMsg.ps == `JSQR_PS_SAVE &&
                       link.reqMsg.data[7:0] == `JSQR_SAVE_REQ) begin
            // remember who asked; the answer goes back with that address
            next_saveReq = link.reqMsg.src;
            next_saveStart = 1'b1; // R18
            next_nvmBusy = 1'b1; // R9
            next_state = jsqr_pkg::JSQR_SAVING;
          end else if (link.reqMsg.ps == `JSQR_PS_ALGO_RESET) begin
            // no answer frame; the startup phase begins again
            next_restartPulse = 1'b1; // R8
            next_starting = 1'b1;
          end
        end
      end
      jsqr_pkg::JSQR_SAVING: begin
        // the memory reports its result in a one-cycle pulse; no new
        // request is taken meanwhile, so the pulse cannot be missed
        if (nvmDone) begin
          next_nvmBusy = 1'b0;
          next_rsp.len = `JSQR_LEN_SAVE; // R19
          // byte 2 result, byte 1 requester address, byte 0 response
          next_rsp.data = {(nvmOk ? `JSQR_SAVE_OK : `JSQR_SAVE_FAIL),
                           saveReq, `JSQR_SAVE_RSP}; // R20
          next_rspValid = 1'b1;
          next_state = jsqr_pkg::JSQR_REPLY;
        end
      end
      jsqr_pkg::JSQR_REPLY: begin
        // answer stands until the controller takes it
        if (link.rspReady) begin
          next_rspValid = 1'b0;
          next_state = jsqr_pkg::JSQR_IDLE;
        end
      end
      default: begin
        // unused code: drop any answer and go idle
        next_state = jsqr_pkg::JSQR_IDLE;
        next_rspValid = 1'b0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset puts the unit in its startup phase with nothing pending
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      state <= jsqr_pkg::JSQR_IDLE;
      rsp <= '0;
      rspValid <= 1'b0;
      reqReady <= 1'b0;
      saveStart <= 1'b0;
      restartPulse <= 1'b0;
      starting <= 1'b1;
      nvmBusy <= 1'b0;
      saveReq <= 8'h0;
    end else begin
      state <= next_state;
      rsp <= next_rsp;
      rspValid <= next_rspValid;
      reqReady <= next_reqReady;
      saveStart <= next_saveStart;
      restartPulse <= next_restartPulse;
      starting <= next_starting;
      nvmBusy <= next_nvmBusy;
      saveReq <= next_saveReq;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output comes straight from a register
  assign link.reqReady = reqReady;
  assign link.rspValid = rspValid;
  assign link.rspMsg = rsp;
  assign nvmSaveStart = saveStart;
  assign algoRestart = restartPulse;
  assign algoStarting = starting;
endmodule

// File: hw/jsqr_controller.sv
// controller end: issues requests and set commands, collects answers
// assumes user holds cmdValid until cmdReady; answers come one at a time
`timescale 1ns/1ps
`include "jsqr_regs.svh"
module jsqr_controller #(
  parameter logic [7:0] OWN_ADDR = 8'h10
) (
  // link
  jsqr_link_if.controller link,
  // user command: ps selects the message, dest the target unit
  input wire logic cmdValid,
  input wire logic [7:0] cmdPs,
  input wire logic [7:0] cmdDest,
  output logic cmdReady,
  // user answer
  output logic ansValid,
  output logic [7:0] ansPs,
  output logic [23:0] ansData
);
  jsqr_pkg::jsqr_msg_type msg, next_msg;
  logic busy, next_busy; // request on the link
  logic done, next_done; // command taken pulse
  logic aValid, next_aValid;
  logic [7:0] aPs, next_aPs;
  logic [23:0] aData, next_aData;
  // ----------------------------------------------------------------
  // request and answer
  // ----------------------------------------------------------------
  // gets name the wanted group; set commands carry the destination
  always_comb begin
    next_msg = msg;
    next_busy = busy;
    next_done = 1'b0;
    next_aValid = 1'b0;
    next_aPs = aPs;
    next_aData = aData;
    if (!busy && !done && cmdValid) begin
      next_msg = '0;
      next_msg.prio = `JSQR_PRIO;
      next_msg.pf = `JSQR_PF;
      next_msg.ps = cmdPs; // R1
      next_msg.src = OWN_ADDR;
      next_msg.len = (cmdPs == `JSQR_PS_SAVE || cmdPs == `JSQR_PS_ALGO_RESET) ?
                     `JSQR_LEN_SAVE : `JSQR_LEN_WORD; // R18
      next_msg.data = {8'h0, cmdDest, `JSQR_SAVE_REQ}; // R17 R20
      next_busy = 1'b1;
    end else if (busy && link.reqReady) begin
      next_busy = 1'b0;
      next_done = 1'b1;
    end
    if (link.rspValid) begin
      next_aValid = 1'b1;
      next_aPs = link.rspMsg.ps;
      next_aData = link.rspMsg.data;
    end
  end
  // registers
  always_ff @(posedge link.clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      msg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      aValid <= 1'b0;
      aPs <= 8'h0;
      aData <= 24'h0;
    end else begin
      msg <= next_msg;
      busy <= next_busy;
      done <= next_done;
      aValid <= next_aValid;
      aPs <= next_aPs;
      aData <= next_aData;
    end
  end
  assign link.reqValid = busy;
  assign link.reqMsg = msg;
  assign link.rspReady = 1'b1; // always drains answers
  assign cmdReady = done;
  assign ansValid = aValid;
  assign ansPs = aPs;
  assign ansData = aData;
endmodule

// File: test/jsqr_link_monitor.sv
// assertions on the link between the controller and the responder
// assumes one clock and an async active-low reset shared by both ends
`timescale 1ns/1ps
module jsqr_link_monitor #(
  parameter logic [7:0] RESP_ADDR = 8'h80
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request direction
  input wire logic reqValid,
  input wire logic reqReady,
  input wire jsqr_pkg::jsqr_msg_type reqMsg,
  // reply direction
  input wire logic rspValid,
  input wire logic rspReady,
  input wire jsqr_pkg::jsqr_msg_type rspMsg
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic taken; // request accepted this edge
  logic foreign; // set command for another unit
  assign taken = reqValid && reqReady;
  assign foreign = (reqMsg.ps == 8'h50 || reqMsg.ps == 8'h51) && reqMsg.data[15:8] != RESP_ADDR;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_req_form;
    reqValid |-> reqMsg.prio == 3'h6 && reqMsg.pf == 8'hff;
  endproperty
  a_req_form: assert property (p_req_form) else $error("bad request identity");
  property p_reply_id;
    rspValid |-> rspMsg.prio == 3'h6 && rspMsg.pf == 8'hff;
  endproperty
  a_reply_id: assert property (p_reply_id) else $error("bad reply identity");
  property p_selftest_word;
    rspValid && rspMsg.ps == 8'h53 |-> rspMsg.len == 4'h2 && rspMsg.data[15:7] == 9'h0
      && rspMsg.data[2] == rspMsg.data[5];
  endproperty
  a_selftest_word: assert property (p_selftest_word) else $error("bad self-test word");
  property p_status_word;
    rspValid && rspMsg.ps == 8'h54 |-> rspMsg.len == 4'h2 && rspMsg.data[15:13] == 3'h0
      && !rspMsg.data[9] && rspMsg.data[6:4] == 3'h0;
  endproperty
  a_status_word: assert property (p_status_word) else $error("bad status word");
  property p_summary;
    rspValid && rspMsg.ps == 8'h54 && (|rspMsg.data[3:1]) |-> rspMsg.data[0];
  endproperty
  a_summary: assert property (p_summary) else $error("summary alert missing");
  property p_save_reply;
    rspValid && rspMsg.ps == 8'h51 |-> rspMsg.len == 4'h3 && rspMsg.data[7:0] == 8'h01
      && rspMsg.data[23:17] == 7'h0;
  endproperty
  a_save_reply: assert property (p_save_reply) else $error("bad save reply");
  property p_query_answer;
    taken && (reqMsg.ps == 8'h53 || reqMsg.ps == 8'h54) |-> ##[1:2] rspValid;
  endproperty
  a_query_answer: assert property (p_query_answer) else $error("query not answered");
  property p_foreign;
    taken && foreign |=> !rspValid [*8];
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign command answered");
  property p_answer_once;
    rspValid && rspReady |=> !rspValid;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("reply repeated");
  // main scenarios seen
  c_selftest: cover property (rspValid && rspMsg.ps == 8'h53);
  c_status: cover property (rspValid && rspMsg.ps == 8'h54);
  c_save_ok: cover property (rspValid && rspMsg.ps == 8'h51 && rspMsg.data[16]);
  c_foreign: cover property (taken && foreign);
endmodule

// File: test/tb.sv
// self-checking bench: controller and responder joined by the link
// assumes design files, package and link interface are compiled first
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  localparam int unsigned INIT = 60; // short startup so the run stays brief
  typedef struct packed {
    logic [9:0] cond; // sw,range,data,cal,hw,swal,sens,att,yaw,nvm
    logic [7:0] ps;
    logic [15:0] want;
  } jsqr_row_type;
  logic clk;
  logic rst_n;
  logic cmdValid;
  logic [7:0] cmdPs;
  logic [7:0] cmdDest;
  logic cmdReady;
  logic ansValid;
  logic [7:0] ansPs;
  logic [23:0] ansData;
  logic [9:0] cond; // sensor conditions, see row layout
  logic nvmDone;
  logic nvmOk;
  logic [1:0] nvmDelay; // stand-in for the memory write time
  logic nvmSaveStart;
  logic algoRestart;
  logic algoStarting;
  logic gotAns;
  logic restartSeen;
  logic saveSeen;
  logic [7:0] ansId;
  logic [23:0] ansWord;
  int failCount = 0;
  int checks = 0;
  // ordinary cases: conditions, query, expected word
  jsqr_row_type rows [0:13] = '{
    '{10'h000, 8'h53, 16'h0000}, '{10'h200, 8'h53, 16'h0001}, '{10'h100, 8'h53, 16'h0012},
    '{10'h080, 8'h53, 16'h0024}, '{10'h040, 8'h53, 16'h0040}, '{10'h03f, 8'h53, 16'h0000},
    '{10'h000, 8'h54, 16'h0000}, '{10'h020, 8'h54, 16'h0003}, '{10'h010, 8'h54, 16'h0005},
    '{10'h008, 8'h54, 16'h0009}, '{10'h00c, 8'h54, 16'h0409}, '{10'h002, 8'h54, 16'h0800},
    '{10'h001, 8'h54, 16'h0080}, '{10'h120, 8'h54, 16'h1003}};
  jsqr_link_if link (.clk(clk), .rst_n(rst_n));
  jsqr_responder #(.INIT_CYCLES(INIT), .OWN_ADDR(8'h80)) jsqr_responder_i (
    .link(link), .swFaultFlag(cond[9]), .rangeExceeded(cond[8]), .dataFaultFlag(cond[7]),
    .calChecksumFault(cond[6]), .hwAlert(cond[5]), .swAlert(cond[4]), .sensingAlert(cond[3]),
    .attitudeAlert(cond[2]), .yawTurnIndicator(cond[1]), .nvmWriteOpen(cond[0]),
    .nvmDone(nvmDone), .nvmOk(nvmOk), .nvmSaveStart(nvmSaveStart),
    .algoRestart(algoRestart), .algoStarting(algoStarting));
  jsqr_controller #(.OWN_ADDR(8'h10)) jsqr_controller_i (
    .link(link), .cmdValid(cmdValid), .cmdPs(cmdPs), .cmdDest(cmdDest), .cmdReady(cmdReady),
    .ansValid(ansValid), .ansPs(ansPs), .ansData(ansData));
  jsqr_link_monitor #(.RESP_ADDR(8'h80)) jsqr_link_monitor_i (
    .clk(clk), .rst_n(rst_n), .reqValid(link.reqValid), .reqReady(link.reqReady),
    .reqMsg(link.reqMsg), .rspValid(link.rspValid), .rspReady(link.rspReady),
    .rspMsg(link.rspMsg));
  // ----------------------------------------------------------------
  // clock, memory stand-in, tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // memory finishes a save four cycles after it starts; drives nvmDone only, nvmOk is set by the sequence
  always @(posedge clk) begin
    if (!rst_n) begin
      nvmDone <= 1'b0;
      nvmDelay <= 2'h0;
    end else begin
      nvmDone <= (nvmDelay == 2'h1);
      nvmDelay <= nvmSaveStart ? 2'h3 : (nvmDelay != 2'h0 ? nvmDelay - 2'h1 : 2'h0);
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    checks++;
    if (seen !== want) begin
      failCount++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask
  // one command; a silent command simply runs the whole bounded wait
  task automatic run(input logic [7:0] ps, input logic [7:0] dest);
    gotAns = 1'b0;
    restartSeen = 1'b0;
    saveSeen = 1'b0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdPs <= ps;
    cmdDest <= dest;
    for (int n = 0; n < 30 && !gotAns; n++) begin
      @(posedge clk);
      if (cmdReady === 1'b1) cmdValid <= 1'b0;
      if (algoRestart === 1'b1) restartSeen = 1'b1;
      if (nvmSaveStart === 1'b1) saveSeen = 1'b1;
      if (ansValid === 1'b1) begin
        gotAns = 1'b1;
        ansId = ansPs;
        ansWord = ansData;
      end
    end
  endtask
  task automatic ask(input logic [7:0] ps, input logic [15:0] want);
    run(ps, 8'h80);
    check(gotAns, 1'b1);
    check(ansId, ps);
    check(ansWord[15:0], want);
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdPs = 8'h0;
    cmdDest = 8'h0;
    cond = 10'h0;
    nvmOk = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (INIT + 10) @(posedge clk);
    foreach (rows[i]) begin
      cond <= rows[i].cond;
      ask(rows[i].ps, rows[i].want);
      $display("row %0d done", i);
    end
    // algorithm reset brings back the startup phase
    cond <= 10'h0;
    run(8'h50, 8'h80);
    check(restartSeen, 1'b1);
    check(algoStarting, 1'b1);
    ask(8'h53, 16'h000a);
    ask(8'h54, 16'h0100);
    repeat (INIT) @(posedge clk);
    ask(8'h53, 16'h0000);
    $display("algorithm reset test done");
    // commands for another unit and unknown queries stay silent
    run(8'h50, 8'h22);
    check({restartSeen, algoStarting}, 2'h0);
    run(8'h51, 8'h22);
    check({saveSeen, gotAns}, 2'h0);
    run(8'h55, 8'h80);
    check(gotAns, 1'b0);
    $display("foreign command test done");
    // save with failure, then success
    for (int k = 0; k < 2; k++) begin
      nvmOk <= k[0];
      run(8'h51, 8'h80);
      check(saveSeen, 1'b1);
      check(ansId, 8'h51);
      check(ansWord, {7'h0, k[0], 16'h1001});
    end
    $display("save test done");
    // reset in mid-run brings back the startup phase
    cond <= 10'h020;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(algoStarting, 1'b1);
    rst_n <= 1'b1;
    ask(8'h54, 16'h0103);
    $display("reset test done");
    stopTest();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    stopTest();
  end
endmodule
